// file: common/spio_pkg.sv
// constants, reset values and register offsets of the shared pin port
// assumes a 16-bit register word on a plain strobe port with 6 address bits
package spio_pkg;

	localparam int NPIN = 16;
	localparam int NCN = 21;
	localparam int NCN_HI = NCN - NPIN;
	localparam int NRP = 16;
	localparam int RPW = 5;
	localparam int AW = 6;
	localparam int DW = 16;
	localparam int LOCK_BIT = 6;

	// register word addresses
	localparam logic [AW-1:0] ADR_DIR = 6'h00;
	localparam logic [AW-1:0] ADR_LAT = 6'h01;
	localparam logic [AW-1:0] ADR_LVL = 6'h02;
	localparam logic [AW-1:0] ADR_ODC = 6'h03;
	localparam logic [AW-1:0] ADR_ANA = 6'h04;
	localparam logic [AW-1:0] ADR_CNEN = 6'h05;
	localparam logic [AW-1:0] ADR_CNEN_HI = 6'h06;
	localparam logic [AW-1:0] ADR_CNPU = 6'h07;
	localparam logic [AW-1:0] ADR_CNPU_HI = 6'h08;
	localparam logic [AW-1:0] ADR_OSC = 6'h09;
	// remap selects occupy 6'h10 to 6'h1F, one per remappable pin
	localparam logic [1:0] ADR_RP_PAGE = 2'h1;

	// values after reset
	localparam logic [DW-1:0] DIR_RST = 16'hFFFF;
	localparam logic [DW-1:0] LAT_RST = 16'h0000;
	localparam logic [DW-1:0] ODC_RST = 16'h0000;
	localparam logic [DW-1:0] ANA_RST = 16'h0000;
	localparam logic [DW-1:0] CN_RST = 16'h0000;
	localparam logic [NCN_HI-1:0] CN_HI_RST = 5'h00;
	localparam logic [RPW-1:0] RP_RST = 5'h00;
	localparam logic LOCK_RST = 1'b0;

	// which port bits exist, which share an output peripheral, which carry analog inputs
	localparam logic [NPIN-1:0] IMPL_MASK = 16'h7FFF;
	localparam logic [NPIN-1:0] PERIPH_MASK = 16'h0FFF;
	localparam logic [NPIN-1:0] ANA_MASK = 16'h00FF;

	// unlock keys for the remap write lock
	localparam logic [7:0] KEY1 = 8'h46;
	localparam logic [7:0] KEY2 = 8'h57;

	typedef enum logic [1:0] {
		UL_IDLE,
		UL_KEY1,
		UL_KEY2
	} spio_unlock_e;

endpackage

// file: common/spio_sync_if.sv
// carries synchronised pin levels and change events from the synchroniser to the port
// assumes both ends run on the same clock
interface spio_sync_if;
	logic [spio_pkg::NPIN-1:0] pin_lvl;
	logic [spio_pkg::NCN-1:0] cn_lvl;
	logic [spio_pkg::NCN-1:0] cn_en;
	logic cn_chg;

	modport syncer (
		output pin_lvl,
		output cn_lvl,
		output cn_chg,
		input cn_en
	);

	modport port (
		input pin_lvl,
		input cn_lvl,
		input cn_chg,
		output cn_en
	);
endinterface

// file: src/spio_sync.sv
// three-stage synchroniser for pad and change-notify inputs, with change detection
// assumes raw inputs are asynchronous to mclk_i
module spio_sync (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// raw inputs
	input wire logic [spio_pkg::NPIN-1:0] pad_i,
	input wire logic [spio_pkg::NCN-1:0] cn_pin_i,
	// toward the port
	spio_sync_if.syncer sif
);
	localparam int W = spio_pkg::NPIN + spio_pkg::NCN;

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_q;
	logic [W-1:0] lvl_d;
	logic [W-1:0] diff;
	logic chg_q;

	// s1 feeds only s2; a level is taken once s2 and s3 agree
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= {cn_pin_i, pad_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_comb begin
		lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
		diff = lvl_d ^ lvl_q;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			lvl_q <= '0;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	// only enabled change-notify inputs raise the event
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			chg_q <= 1'b0;
		end else begin
			chg_q <= |(diff[W-1:spio_pkg::NPIN] & sif.cn_en);
		end
	end

	assign sif.pin_lvl = lvl_q[spio_pkg::NPIN-1:0];
	assign sif.cn_lvl = lvl_q[W-1:spio_pkg::NPIN];
	assign sif.cn_chg = chg_q;

	a_cn_enabled_only: assert property (@(posedge mclk_i) disable iff (rst_i)
		chg_q |-> |($past(diff[W-1:spio_pkg::NPIN]) & $past(sif.cn_en)))
		else $error("change event without an enabled change");

	a_sync_agree: assert property (@(posedge mclk_i) disable iff (rst_i)
		$changed(lvl_q) |-> (($past(lvl_q) ^ lvl_q) & ~($past(s2_q) ~^ $past(s3_q))) == '0)
		else $error("level taken while stages disagreed");

endmodule // spio_sync

// file: src/spio_port.sv
// shared pin parallel port: direction, latch, pin read, open drain, analog masking,
// change notification and the remap select table with its write lock
// assumes a plain strobe register port on mclk_i and asynchronous pads
//
// The implementer's own choices: strobed register access and the address map.
module spio_port (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// register port
	input wire logic [spio_pkg::AW-1:0] addr_i,
	input wire logic [spio_pkg::DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [spio_pkg::DW-1:0] rdata_o,
	// pads
	input wire logic [spio_pkg::NPIN-1:0] pad_i,
	output logic [spio_pkg::NPIN-1:0] pad_o,
	output logic [spio_pkg::NPIN-1:0] pad_oe_o,
	// sharing peripherals
	input wire logic [spio_pkg::NPIN-1:0] periph_en_i,
	input wire logic [spio_pkg::NPIN-1:0] periph_drive_i,
	input wire logic [spio_pkg::NPIN-1:0] periph_out_i,
	output logic [spio_pkg::NPIN-1:0] periph_in_o,
	output logic [spio_pkg::NPIN-1:0] analog_mode_o,
	// change notification
	input wire logic [spio_pkg::NCN-1:0] cn_pin_i,
	output logic [spio_pkg::NCN-1:0] cn_pullup_o,
	output logic cn_irq_o,
	// remap table
	output logic [spio_pkg::NRP*spio_pkg::RPW-1:0] remap_sel_o,
	output logic remap_lock_o
);

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	logic [spio_pkg::DW-1:0] dir_q;
	logic [spio_pkg::DW-1:0] lat_q;
	logic [spio_pkg::DW-1:0] odc_q;
	logic [spio_pkg::DW-1:0] ana_q;
	logic [spio_pkg::DW-1:0] cnen_q;
	logic [spio_pkg::NCN_HI-1:0] cnen_hi_q;
	logic [spio_pkg::DW-1:0] cnpu_q;
	logic [spio_pkg::NCN_HI-1:0] cnpu_hi_q;
	logic [spio_pkg::RPW-1:0] rp_q [spio_pkg::NRP];
	logic lock_q;
	spio_pkg::spio_unlock_e ul_q;
	logic [spio_pkg::DW-1:0] rdata_q;
	logic [spio_pkg::DW-1:0] rdata_d;
	logic [spio_pkg::NPIN-1:0] pad_q;
	logic [spio_pkg::NPIN-1:0] pad_oe_q;
	logic [spio_pkg::NPIN-1:0] pin_in_q;
	logic [spio_pkg::NPIN-1:0] owns;
	logic [spio_pkg::NPIN-1:0] port_drv;
	logic [spio_pkg::NPIN-1:0] out_val;
	logic [spio_pkg::NPIN-1:0] lvl_rd;
	logic rp_hit;
	logic [3:0] rp_idx;

	spio_sync_if sif ();

	spio_sync u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.pad_i(pad_i),
		.cn_pin_i(cn_pin_i),
		.sif(sif)
	);

	// bits that do not exist are stored as zero by latch and open-drain writes and read as zero from direction, latch and level
	function automatic logic [spio_pkg::DW-1:0] impl_only(input logic [spio_pkg::DW-1:0] v);
		impl_only = v & spio_pkg::IMPL_MASK;
	endfunction

	assign rp_hit = (addr_i[5:4] == spio_pkg::ADR_RP_PAGE);
	assign rp_idx = addr_i[3:0];

	// port registers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			dir_q <= spio_pkg::DIR_RST;
			lat_q <= spio_pkg::LAT_RST;
			odc_q <= spio_pkg::ODC_RST;
			ana_q <= spio_pkg::ANA_RST;
		end else if (wr_i) begin
			unique case (addr_i)
				spio_pkg::ADR_DIR: dir_q <= wdata_i;
				spio_pkg::ADR_LAT: lat_q <= impl_only(wdata_i);
				spio_pkg::ADR_LVL: lat_q <= impl_only(wdata_i);
				spio_pkg::ADR_ODC: odc_q <= impl_only(wdata_i);
				spio_pkg::ADR_ANA: ana_q <= wdata_i;
				default: ;
			endcase
		end
	end

	// change-notify enables and pull-ups
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnen_q <= spio_pkg::CN_RST;
			cnen_hi_q <= spio_pkg::CN_HI_RST;
			cnpu_q <= spio_pkg::CN_RST;
			cnpu_hi_q <= spio_pkg::CN_HI_RST;
		end else if (wr_i) begin
			unique case (addr_i)
				spio_pkg::ADR_CNEN: cnen_q <= wdata_i;
				spio_pkg::ADR_CNEN_HI: cnen_hi_q <= wdata_i[spio_pkg::NCN_HI-1:0];
				spio_pkg::ADR_CNPU: cnpu_q <= wdata_i;
				spio_pkg::ADR_CNPU_HI: cnpu_hi_q <= wdata_i[spio_pkg::NCN_HI-1:0];
				default: ;
			endcase
		end
	end

	assign sif.cn_en = {cnen_hi_q, cnen_q};
	assign cn_pullup_o = {cnpu_hi_q, cnpu_q};
	// the event is already a registered one-cycle pulse from the synchroniser
	assign cn_irq_o = sif.cn_chg;

	// unlock sequence: any write elsewhere, or a wrong key, starts it over
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ul_q <= spio_pkg::UL_IDLE;
		end else if (wr_i) begin
			if (addr_i != spio_pkg::ADR_OSC) begin
				ul_q <= spio_pkg::UL_IDLE;
			end else begin
				unique case (ul_q)
					spio_pkg::UL_IDLE: begin
						ul_q <= (wdata_i[7:0] == spio_pkg::KEY1) ? spio_pkg::UL_KEY1 :
							spio_pkg::UL_IDLE;
					end
					spio_pkg::UL_KEY1: begin
						if (wdata_i[7:0] == spio_pkg::KEY2) begin
							ul_q <= spio_pkg::UL_KEY2;
						end else if (wdata_i[7:0] == spio_pkg::KEY1) begin
							ul_q <= spio_pkg::UL_KEY1;
						end else begin
							ul_q <= spio_pkg::UL_IDLE;
						end
					end
					spio_pkg::UL_KEY2: ul_q <= spio_pkg::UL_IDLE;
				endcase
			end
		end
	end

	// the lock stays put until the next full sequence
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			lock_q <= spio_pkg::LOCK_RST;
		end else if (wr_i && addr_i == spio_pkg::ADR_OSC && ul_q == spio_pkg::UL_KEY2) begin
			lock_q <= wdata_i[spio_pkg::LOCK_BIT];
		end
	end

	// remap selects, guarded by the lock
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < spio_pkg::NRP; i++) begin
				rp_q[i] <= spio_pkg::RP_RST;
			end
		end else if (wr_i && rp_hit && !lock_q) begin
			rp_q[rp_idx] <= wdata_i[spio_pkg::RPW-1:0];
		end
	end

	always_comb begin
		for (int i = 0; i < spio_pkg::NRP; i++) begin
			remap_sel_o[i*spio_pkg::RPW +: spio_pkg::RPW] = rp_q[i];
		end
	end

	assign remap_lock_o = lock_q;

	// pin ownership; pins outside the peripheral mask only have input sharers
	always_comb begin
		owns = periph_en_i & periph_drive_i & spio_pkg::PERIPH_MASK & spio_pkg::IMPL_MASK;
		port_drv = ~dir_q & ~owns & spio_pkg::IMPL_MASK;
		out_val = (owns & periph_out_i) | (~owns & lat_q);
	end

	// pad drive is registered, so a peripheral takeover lands one cycle late
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pad_q <= '0;
			pad_oe_q <= '0;
		end else begin
			pad_q <= out_val & ~odc_q;
			pad_oe_q <= (owns | port_drv) & ~(odc_q & out_val);
		end
	end

	assign pad_o = pad_q;
	assign pad_oe_o = pad_oe_q;
	assign analog_mode_o = spio_pkg::ANA_MASK & ~ana_q & spio_pkg::IMPL_MASK;

	// peripheral input sees the pad only when the port is not driving it
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_in_q <= '0;
		end else begin
			pin_in_q <= sif.pin_lvl & ~port_drv & ~analog_mode_o & spio_pkg::IMPL_MASK;
		end
	end

	assign periph_in_o = pin_in_q;

	// read path; analog pins read low, the converter still needs direction input
	always_comb begin
		lvl_rd = impl_only(sif.pin_lvl & ~analog_mode_o);
		rdata_d = '0;
		if (rp_hit) begin
			rdata_d[spio_pkg::RPW-1:0] = rp_q[rp_idx];
		end else begin
			unique case (addr_i)
				spio_pkg::ADR_DIR: rdata_d = impl_only(dir_q);
				spio_pkg::ADR_LAT: rdata_d = impl_only(lat_q);
				spio_pkg::ADR_LVL: rdata_d = lvl_rd;
				spio_pkg::ADR_ODC: rdata_d = odc_q;
				spio_pkg::ADR_ANA: rdata_d = ana_q;
				spio_pkg::ADR_CNEN: rdata_d = cnen_q;
				spio_pkg::ADR_CNEN_HI: rdata_d[spio_pkg::NCN_HI-1:0] = cnen_hi_q;
				spio_pkg::ADR_CNPU: rdata_d = cnpu_q;
				spio_pkg::ADR_CNPU_HI: rdata_d[spio_pkg::NCN_HI-1:0] = cnpu_hi_q;
				spio_pkg::ADR_OSC: rdata_d[spio_pkg::LOCK_BIT] = lock_q;
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rd_i ? rdata_d : '0;
		end
	end

	assign rdata_o = rdata_q;

	// a first key written as the closing write of a sequence does not start a new one
	sequence s_key1;
		wr_i && addr_i == spio_pkg::ADR_OSC && wdata_i[7:0] == spio_pkg::KEY1 &&
			ul_q != spio_pkg::UL_KEY2;
	endsequence

	sequence s_key2;
		wr_i && addr_i == spio_pkg::ADR_OSC && wdata_i[7:0] == spio_pkg::KEY2;
	endsequence

	sequence s_lock_wr;
		wr_i && addr_i == spio_pkg::ADR_OSC;
	endsequence

	a_dir_reset: assert property ($past(rst_i) |-> dir_q == spio_pkg::DIR_RST)
		else $error("direction not all input after reset");

	a_ana_reset: assert property ($past(rst_i) |-> ana_q == spio_pkg::ANA_RST)
		else $error("analog config not cleared after reset");

	a_periph_owns: assert property (1 |=>
		((pad_o ^ ($past(periph_out_i) & ~$past(odc_q))) & $past(owns)) == '0)
		else $error("peripheral value not on an owned pin");

	a_input_float: assert property (1 |=> (pad_oe_o & $past(dir_q) & ~$past(owns)) == '0)
		else $error("input pin driven by port");

	a_port_drives: assert property (1 |=>
		(($past(port_drv) & ~$past(odc_q)) & ~pad_oe_o) == '0)
		else $error("port bit not driving its output pin");

	a_no_loop: assert property (1 |=> (periph_in_o & $past(port_drv)) == '0)
		else $error("port output looped into peripheral input");

	a_open_drain: assert property (1 |=> (pad_oe_o & $past(odc_q) & $past(out_val)) == '0)
		else $error("open drain pin driven high");

	a_lat_read: assert property (rd_i && addr_i == spio_pkg::ADR_LAT |=>
		rdata_o == ($past(lat_q) & spio_pkg::IMPL_MASK))
		else $error("latch read wrong");

	a_lvl_write: assert property (wr_i && addr_i == spio_pkg::ADR_LVL |=>
		lat_q == ($past(wdata_i) & spio_pkg::IMPL_MASK))
		else $error("level write did not reach latch");

	a_unimpl_zero: assert property (rd_i && addr_i <= spio_pkg::ADR_LVL |=>
		(rdata_o & ~spio_pkg::IMPL_MASK) == '0)
		else $error("unimplemented bit read nonzero");

	a_analog_read: assert property (rd_i && addr_i == spio_pkg::ADR_LVL |=>
		(rdata_o & $past(analog_mode_o)) == '0)
		else $error("analog pin read nonzero");

	a_unlock_seq: assert property (s_key1 ##1 s_key2 ##1 s_lock_wr |=>
		lock_q == $past(wdata_i[spio_pkg::LOCK_BIT]))
		else $error("lock not changed after full sequence");

	a_lock_keys: assert property ($changed(lock_q) |-> $past(ul_q) == spio_pkg::UL_KEY2)
		else $error("lock changed without keys");

	a_lock_hold: assert property (wr_i && rp_hit && lock_q |=>
		rp_q[$past(rp_idx)] == $past(rp_q[rp_idx]))
		else $error("remap select changed while locked");

endmodule // spio_port

// file: verif/spio_pads_model.sv
// external circuitry on the shared pads: pull-up resistors and optional outside drivers
// assumes the port's pad outputs are registered on the bench clock
module spio_pads_model (
	// port side of the pads
	input wire logic [spio_pkg::NPIN-1:0] pad_drv_i,
	input wire logic [spio_pkg::NPIN-1:0] pad_oe_i,
	// outside drivers, set by the bench
	input wire logic [spio_pkg::NPIN-1:0] ext_en_i,
	input wire logic [spio_pkg::NPIN-1:0] ext_val_i,
	// resolved pad level
	output logic [spio_pkg::NPIN-1:0] pad_lvl_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// a released pad is pulled high, so an open-drain high reads as one
	always_comb begin
		for (int i = 0; i < spio_pkg::NPIN; i++) begin
			if (pad_oe_i[i]) begin
				pad_lvl_o[i] = pad_drv_i[i];
			end else if (ext_en_i[i]) begin
				pad_lvl_o[i] = ext_val_i[i];
			end else begin
				pad_lvl_o[i] = 1'b1;
			end
		end
	end
endmodule // spio_pads_model

// file: verif/spio_port_tb.sv
// self-checking bench for the shared pin port
// assumes the pad model closes the pad loop and the bench plays software
module spio_port_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic mclk, rst, wr, rd, cn_irq, rlock;
	logic [5:0] addr;
	logic [15:0] wdata, rdata, pad_in, pad_out, pad_oe, p_en, p_drv, p_out, p_in, ana_mode;
	logic [15:0] ext_en, ext_val;
	logic [20:0] cn_pin, cn_pu;
	logic [79:0] rsel;
	int err_count, checks_done, cycles;

	spio_port spio_port_i (
		.mclk_i(mclk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .pad_i(pad_in), .pad_o(pad_out), .pad_oe_o(pad_oe),
		.periph_en_i(p_en), .periph_drive_i(p_drv), .periph_out_i(p_out),
		.periph_in_o(p_in), .analog_mode_o(ana_mode), .cn_pin_i(cn_pin),
		.cn_pullup_o(cn_pu), .cn_irq_o(cn_irq), .remap_sel_o(rsel), .remap_lock_o(rlock)
	);

	spio_pads_model spio_pads_model_i (
		.pad_drv_i(pad_out), .pad_oe_i(pad_oe), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.pad_lvl_o(pad_in)
	);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// the whole run needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("mismatches=%0d comparisons=%0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wreg(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rreg(input logic [5:0] a, input logic [15:0] e);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	task automatic t_reset();
		chk(pad_oe, 16'h0000);
		chk(ana_mode, 16'h00FF);
		rreg(spio_pkg::ADR_DIR, 16'h7FFF);
		rreg(spio_pkg::ADR_ANA, 16'h0000);
		rreg(spio_pkg::ADR_LAT, 16'h0000);
		rreg(6'h0A, 16'h0000);
	endtask

	task automatic t_latch();
		wreg(spio_pkg::ADR_ANA, 16'hFFFF);
		wreg(spio_pkg::ADR_LAT, 16'hFFFF);
		rreg(spio_pkg::ADR_LAT, 16'h7FFF);
		wreg(spio_pkg::ADR_DIR, 16'h0000);
		cyc(1);
		rreg(spio_pkg::ADR_DIR, 16'h0000);
		chk({pad_oe, pad_out}, {16'h7FFF, 16'h7FFF});
		cyc(6);
		rreg(spio_pkg::ADR_LVL, 16'h7FFF);
		wreg(spio_pkg::ADR_LVL, 16'h1234);
		cyc(1);
		rreg(spio_pkg::ADR_LAT, 16'h1234);
		wreg(spio_pkg::ADR_DIR, 16'hFFFF);
		cyc(2);
		chk(pad_oe, 16'h0000);
	endtask

	task automatic t_open_drain();
		wreg(spio_pkg::ADR_DIR, 16'h0000);
		wreg(spio_pkg::ADR_LAT, 16'h00FF);
		wreg(spio_pkg::ADR_ODC, 16'h00F0);
		cyc(2);
		chk({pad_oe, pad_out}, {16'h7F0F, 16'h000F});
		wreg(spio_pkg::ADR_ODC, 16'h0000);
	endtask

	task automatic t_periph();
		wreg(spio_pkg::ADR_LAT, 16'h1002);
		@(posedge mclk);
		p_en <= 16'h1003;
		p_drv <= 16'h1001;
		p_out <= 16'h0001;
		cyc(8);
		chk({pad_oe, pad_out}, {16'h7FFF, 16'h1003});
		chk(p_in, 16'h0001);
		rreg(spio_pkg::ADR_LVL, 16'h1003);
		@(posedge mclk);
		p_en <= 16'h0000;
		p_drv <= 16'h0000;
	endtask

	task automatic t_analog();
		wreg(spio_pkg::ADR_DIR, 16'hFFFF);
		@(posedge mclk);
		ext_en <= 16'hFFFF;
		ext_val <= 16'hFFFF;
		wreg(spio_pkg::ADR_ANA, 16'h0000);
		cyc(6);
		chk(ana_mode, 16'h00FF);
		rreg(spio_pkg::ADR_LVL, 16'h7F00);
		wreg(spio_pkg::ADR_ANA, 16'h000F);
		cyc(1);
		chk(ana_mode, 16'h00F0);
		rreg(spio_pkg::ADR_LVL, 16'h7F0F);
	endtask

	task automatic cn_flip(input logic [20:0] m, input int e);
		int n;
		n = 0;
		@(posedge mclk);
		cn_pin <= cn_pin ^ m;
		repeat (10) begin
			@(posedge mclk);
			#1;
			if (cn_irq === 1'b1) n++;
		end
		chk(80'(n), 80'(e));
	endtask

	task automatic t_change();
		wreg(spio_pkg::ADR_CNEN, 16'h0003);
		wreg(spio_pkg::ADR_CNEN_HI, 16'h0010);
		wreg(spio_pkg::ADR_CNPU, 16'h00AA);
		wreg(spio_pkg::ADR_CNPU_HI, 16'h0015);
		cyc(6);
		chk(cn_pu, {5'h15, 16'h00AA});
		rreg(spio_pkg::ADR_CNPU_HI, 16'h0015);
		cn_flip(21'h000001, 1);
		cn_flip(21'h000004, 0);
		cn_flip(21'h100000, 1);
		cn_flip(21'h000003, 1);
	endtask

	task automatic key(input logic [15:0] k2, input logic [15:0] last);
		wreg(spio_pkg::ADR_OSC, 16'h0046);
		wreg(spio_pkg::ADR_OSC, k2);
		wreg(spio_pkg::ADR_OSC, last);
		cyc(1);
	endtask

	// unlock with the three writes on consecutive cycles, strobe held high throughout
	task automatic key_b2b(input logic [15:0] last);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= spio_pkg::ADR_OSC;
		wdata <= 16'h0046;
		@(posedge mclk);
		wdata <= 16'h0057;
		@(posedge mclk);
		wdata <= last;
		@(posedge mclk);
		wr <= 1'b0;
		cyc(1);
	endtask

	task automatic t_remap();
		wreg(6'h10, 16'h0003);
		wreg(6'h1F, 16'h001F);
		cyc(1);
		chk({rsel[79:75], rsel[4:0]}, {5'h1F, 5'h03});
		key_b2b(16'h0040);
		chk(rlock, 1'b1);
		rreg(spio_pkg::ADR_OSC, 16'h0040);
		wreg(6'h10, 16'h0005);
		rreg(6'h10, 16'h0003);
		key(16'h0058, 16'h0000);
		chk(rlock, 1'b1);
		key(16'h0057, 16'h0000);
		chk(rlock, 1'b0);
		wreg(6'h10, 16'h0005);
		rreg(6'h10, 16'h0005);
	endtask

	initial begin
		{rst, wr, rd} = 3'b100;
		{addr, wdata, p_en, p_drv, p_out, ext_en, ext_val, cn_pin} = '0;
		err_count = 0;
		checks_done = 0;
		cycles = 0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk(rlock, 1'b0);
		t_reset();
		t_latch();
		t_open_drain();
		t_periph();
		t_analog();
		t_change();
		t_remap();
		summarize();
	end
endmodule // spio_port_tb
